// [rtl/cxw_defines.svh]
/*
 Constants for the spare byte update and memory write command block:
 register offsets, opcodes, answer codes, memory sizes and config layout.
 Assumes it is included by bare name after the package is compiled.
*/
`ifndef CXW_DEFINES_SVH
`define CXW_DEFINES_SVH

// ==========================================
// Register offsets (byte addresses) and the data and MAC page numbers
`define CXW_REG_CMD 8'h00
`define CXW_REG_SECOND_ARGUMENT 8'h04
`define CXW_REG_CTRL 8'h08
`define CXW_REG_STATUS 8'h0C
`define CXW_REG_LOCK 8'h10
`define CXW_REG_MEM_SEL 8'h14
`define CXW_REG_MEM_DATA 8'h18
`define CXW_DATA_PAGE 3'h1
`define CXW_MAC_PAGE 3'h2

// ==========================================
// Opcodes and answers
`define CXW_OP_SPARE 8'h20
`define CXW_OP_WRITE 8'h12
`define CXW_RESP_OK 8'h00
`define CXW_RESP_PARSE 8'h03
`define CXW_RESP_EXEC 8'h0F
`define CXW_RESP_MAC 8'h01

// ==========================================
// Memory sizes and config word indices, in 32-bit words
`define CXW_CFG_WORDS 22
`define CXW_OTP_WORDS 16
`define CXW_DAT_WORDS 128
`define CXW_CFG_WP_LAST 7'h03
`define CXW_CFG_SPARE_WORD 5'h15
`define CXW_CFG_MODE_WORD 5'h04
`define CXW_CFG_POLICY_BASE 5'h05

// ==========================================
// Field positions and field values
`define CXW_OTP_POLICY_LSB 16
`define CXW_PICK_EN_LSB 24
`define CXW_POL_ENC_BIT 14
`define CXW_POL_WR_LSB 12
`define CXW_POL_KEY_LSB 8
`define CXW_POL_HIDDEN_BIT 7
`define CXW_POL_WR_ALWAYS 4'h0
`define CXW_OTP_RDONLY 8'hAA
`define CXW_OTP_LEGACY 8'h00

`endif

// [rtl/cxw_pkg.sv]
/*
 Types for the spare byte update and memory write command block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package cxw_pkg;
   typedef enum logic [1:0] {CXW_ZONE_CFG, CXW_ZONE_OTP, CXW_ZONE_DATA, CXW_ZONE_BAD} cxw_zone_t;
   typedef enum logic [1:0] {CXW_IDLE, CXW_CHECK, CXW_WRITE} cxw_state_t;
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] param1;
      logic [15:0] second_argument;
   } cxw_cmd_t;
   typedef struct packed {
      logic valid;
      logic digest;
      logic from_rng;
      logic [3:0] source_slot;
      logic [255:0] key;
   } cxw_scratch_t;
endpackage

// [rtl/cxw_core.sv]
/*
 Command executor for the spare byte update and memory write commands,
 holding config, OTP and data zones, behind an Avalon-MM slave.
 Assumes the scratch key register and the hash of the MAC message come
 from neighbouring blocks and stay stable while a command runs.
*/
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`include "cxw_defines.svh"

module cxw_core
   import cxw_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire cxw_scratch_t scratch_key_register,
   input wire logic [255:0] mac_calc,
   output logic cmd_busy
);

   // ==========================================
   // Reset release
   logic rst_meta_b;
   logic rst_sync_b;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   // ==========================================
   // State
   cxw_state_t state;
   cxw_cmd_t cmd;
   logic [31:0] data_reg [8];
   logic [31:0] mac_reg [8];
   logic [31:0] cfg_mem [`CXW_CFG_WORDS];
   logic [31:0] otp_mem [`CXW_OTP_WORDS];
   logic [31:0] dat_mem [`CXW_DAT_WORDS];
   logic cfg_locked;
   logic data_locked;
   logic [9:0] mem_sel;
   logic done;
   logic [7:0] resp;
   logic [2:0] idx;
   logic enc_q;
   logic consume_q;
   logic rd_ack;

   // ==========================================
   // Bus decode
   wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire idle = state == CXW_IDLE;
   wire wr_cmd = avs_write && avs_address == `CXW_REG_CMD && idle;
   wire wr_p2 = avs_write && avs_address == `CXW_REG_SECOND_ARGUMENT && idle;
   wire wr_ctrl = avs_write && avs_address == `CXW_REG_CTRL;
   wire wr_lock = avs_write && avs_address == `CXW_REG_LOCK && idle;
   wire wr_msel = avs_write && avs_address == `CXW_REG_MEM_SEL;
   wire wr_data = avs_write && avs_address[7:5] == `CXW_DATA_PAGE && idle;
   wire wr_mac = avs_write && avs_address[7:5] == `CXW_MAC_PAGE && idle;
   wire go = wr_ctrl && avs_writedata[0] && idle;
   wire [2:0] page_idx = avs_address[4:2];

   assign avs_waitrequest = avs_read && !rd_ack;
   assign cmd_busy = !idle;

   // ==========================================
   // Command fields
   wire [1:0] zone = cmd.param1[1:0];
   wire big = cmd.param1[7];
   wire enc_flag = cmd.param1[6];
   wire [3:0] blk = cmd.second_argument[6:3];
   wire [2:0] wsel = cmd.second_argument[2:0];
   wire [6:0] word_addr = cmd.second_argument[6:0];
   wire addr_hi = |cmd.second_argument[15:7];
   wire is_cfg = zone == CXW_ZONE_CFG;
   wire is_otp = zone == CXW_ZONE_OTP;
   wire is_dat = zone == CXW_ZONE_DATA;

   // ==========================================
   // Config fields
   wire [4:0] pol_word = `CXW_CFG_POLICY_BASE + {2'b00, blk[3:1]};
   wire [31:0] pol_pair = cfg_mem[pol_word];
   wire [15:0] slot_pol = blk[0] ? pol_pair[31:16] : pol_pair[15:0];
   wire [31:0] mode_word = cfg_mem[`CXW_CFG_MODE_WORD];
   wire [7:0] otp_pol = mode_word[`CXW_OTP_POLICY_LSB +: 8];
   wire [7:0] pick_en = mode_word[`CXW_PICK_EN_LSB +: 8];
   wire [31:0] spare_word = cfg_mem[`CXW_CFG_SPARE_WORD];
   wire [7:0] cust_byte = spare_word[7:0];
   wire [7:0] dev_pick = spare_word[15:8];
   wire pol_always = slot_pol[`CXW_POL_WR_LSB +: 4] == `CXW_POL_WR_ALWAYS;
   wire pol_hidden = slot_pol[`CXW_POL_HIDDEN_BIT];
   wire pol_enc = slot_pol[`CXW_POL_ENC_BIT];
   wire [3:0] pol_key = slot_pol[`CXW_POL_KEY_LSB +: 4];

   // ==========================================
   // Spare byte update decision
   wire sp_param_bad = |cmd.param1[7:1] || |cmd.second_argument[15:8];
   wire sp_sel85 = cmd.param1[0];
   wire sp_allow = sp_sel85 ? (pick_en == 8'h00 || dev_pick == 8'h00)
                            : cust_byte == 8'h00;
   wire [7:0] sp_code = sp_param_bad ? `CXW_RESP_PARSE :
                        !cfg_locked ? `CXW_RESP_EXEC :
                        sp_allow ? `CXW_RESP_OK : `CXW_RESP_EXEC;

   // ==========================================
   // Write decision
   wire wr_param_bad = |cmd.param1[5:2] || zone == CXW_ZONE_BAD;
   // Block 2 of config is short, so only the two whole blocks take 32 bytes
   wire range_bad = addr_hi ||
                    (is_cfg && (big ? blk >= 4'h2 : word_addr >= 7'd22)) ||
                    (is_otp && (big ? blk >= 4'h2 : word_addr >= 7'd16));
   wire wp_hit = is_cfg && (big ? blk == 4'h0
                 : (word_addr <= `CXW_CFG_WP_LAST || word_addr == 7'd21));
   wire enc_eff = data_locked ? (is_dat && pol_enc) : enc_flag;
   wire key_ok = scratch_key_register.valid && scratch_key_register.digest &&
                 (!data_locked || (scratch_key_register.source_slot == pol_key &&
                                   scratch_key_register.from_rng));
   logic [255:0] mac_flat;
   wire mac_ok = mac_flat == mac_calc;
   wire otp_ro = is_otp && data_locked &&
                 (otp_pol == `CXW_OTP_RDONLY || otp_pol == `CXW_OTP_LEGACY);
   wire otp_enc = is_otp && data_locked && enc_flag;
   wire short_bad = !big && (!data_locked || enc_eff ||
                    (is_dat && (pol_hidden || !pol_always)));
   wire dat_pol_bad = is_dat && data_locked && !enc_eff && !pol_always;
   wire need_mac = enc_eff && is_dat && data_locked;

   wire [7:0] cfg_code = (cfg_locked || enc_flag) ? `CXW_RESP_EXEC :
                         range_bad ? `CXW_RESP_PARSE :
                         wp_hit ? `CXW_RESP_PARSE : `CXW_RESP_OK;
   wire [7:0] mem_code = !cfg_locked ? `CXW_RESP_EXEC :
                         range_bad ? `CXW_RESP_PARSE :
                         (otp_enc || otp_ro) ? `CXW_RESP_EXEC :
                         (short_bad || dat_pol_bad) ? `CXW_RESP_EXEC :
                         (enc_eff && !key_ok) ? `CXW_RESP_EXEC :
                         (need_mac && !mac_ok) ? `CXW_RESP_MAC : `CXW_RESP_OK;
   wire [7:0] wr_code = wr_param_bad ? `CXW_RESP_PARSE : is_cfg ? cfg_code : mem_code;

   wire is_spare = cmd.opcode == `CXW_OP_SPARE;
   wire is_write = cmd.opcode == `CXW_OP_WRITE;
   wire [7:0] chk_code = is_spare ? sp_code : is_write ? wr_code : `CXW_RESP_PARSE;
   wire in_check = state == CXW_CHECK;
   wire spare_fire = in_check && is_spare && sp_code == `CXW_RESP_OK;
   wire start_write = in_check && is_write && wr_code == `CXW_RESP_OK;

   // ==========================================
   // Write data path
   wire in_write = state == CXW_WRITE;
   wire last_word = !big || idx == 3'h7;
   wire [6:0] tgt = big ? {blk, idx} : word_addr;
   wire [2:0] kidx = big ? idx : wsel;
   wire [31:0] in_word = data_reg[big ? idx : 3'h0];
   wire [31:0] key_word = scratch_key_register.key[{kidx, 5'h00} +: 32];
   wire [31:0] in_plain = enc_q ? (in_word ^ key_word) : in_word;
   wire [31:0] otp_old = otp_mem[tgt[3:0]];
   wire [31:0] otp_new = consume_q ? (otp_old & in_plain) : in_plain;

   // ==========================================
   // Register reads
   wire [6:0] msel_idx = mem_sel[6:0];
   wire [31:0] cfg_rd = (msel_idx < 7'd22) ? cfg_mem[msel_idx[4:0]] : 32'h0000_0000;
   wire [31:0] mem_rd = mem_sel[9:8] == CXW_ZONE_CFG ? cfg_rd :
                        mem_sel[9:8] == CXW_ZONE_OTP ? otp_mem[msel_idx[3:0]] :
                        mem_sel[9:8] == CXW_ZONE_DATA ? dat_mem[msel_idx] : 32'h0000_0000;
   wire [31:0] status_rd = {16'h0000, resp, 6'h00, done, !idle};
   wire [31:0] rd_mux =
      avs_address == `CXW_REG_CMD ? {16'h0000, cmd.param1, cmd.opcode} :
      avs_address == `CXW_REG_SECOND_ARGUMENT ? {16'h0000, cmd.second_argument} :
      avs_address == `CXW_REG_STATUS ? status_rd :
      avs_address == `CXW_REG_LOCK ? {30'h0000_0000, data_locked, cfg_locked} :
      avs_address == `CXW_REG_MEM_SEL ? {22'h00_0000, mem_sel} :
      avs_address == `CXW_REG_MEM_DATA ? mem_rd :
      avs_address[7:5] == `CXW_DATA_PAGE ? data_reg[page_idx] :
      avs_address[7:5] == `CXW_MAC_PAGE ? mac_reg[page_idx] : 32'h0000_0000;

   // One wait state lets the read data come from a flip-flop
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         rd_ack <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         rd_ack <= avs_read && !rd_ack;
         if (avs_read && !rd_ack) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   // ==========================================
   // Software registers
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         cmd <= '0;
         cfg_locked <= 1'b0;
         data_locked <= 1'b0;
         mem_sel <= 10'h000;
      end else begin
         if (wr_cmd) begin
            cmd.opcode <= (cmd.opcode & ~be_mask[7:0]) | (avs_writedata[7:0] & be_mask[7:0]);
            cmd.param1 <= (cmd.param1 & ~be_mask[15:8]) | (avs_writedata[15:8] & be_mask[15:8]);
         end
         if (wr_p2) begin
            cmd.second_argument <= (cmd.second_argument & ~be_mask[15:0]) | (avs_writedata[15:0] & be_mask[15:0]);
         end
         if (wr_lock) begin
            cfg_locked <= avs_writedata[0];
            data_locked <= avs_writedata[1];
         end
         if (wr_msel) begin
            mem_sel <= avs_writedata[9:0];
         end
      end
   end

   // Data and MAC words, one per entry
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_word
         always_ff @(posedge clk or negedge rst_sync_b) begin
            if (!rst_sync_b) begin
               data_reg[gi] <= 32'h0000_0000;
               mac_reg[gi] <= 32'h0000_0000;
            end else begin
               if (wr_data && page_idx == gi) begin
                  data_reg[gi] <= (data_reg[gi] & ~be_mask) | (avs_writedata & be_mask);
               end
               if (wr_mac && page_idx == gi) begin
                  mac_reg[gi] <= (mac_reg[gi] & ~be_mask) | (avs_writedata & be_mask);
               end
            end
         end
         assign mac_flat[gi * 32 +: 32] = mac_reg[gi];
      end
   endgenerate

   // ==========================================
   // Sequencer
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state <= CXW_IDLE;
         done <= 1'b0;
         resp <= `CXW_RESP_OK;
         idx <= 3'h0;
         enc_q <= 1'b0;
         consume_q <= 1'b0;
      end else begin
         unique case (state)
            CXW_IDLE: begin
               if (go) begin
                  state <= CXW_CHECK;
                  done <= 1'b0;
               end
            end
            CXW_CHECK: begin
               idx <= 3'h0;
               enc_q <= enc_eff;
               consume_q <= is_otp && data_locked;
               if (start_write) begin
                  state <= CXW_WRITE;
               end else begin
                  state <= CXW_IDLE;
                  resp <= chk_code;
                  done <= 1'b1;
               end
            end
            CXW_WRITE: begin
               idx <= idx + 3'h1;
               if (last_word) begin
                  state <= CXW_IDLE;
                  resp <= `CXW_RESP_OK;
                  done <= 1'b1;
               end
            end
         endcase
      end
   end

   // ==========================================
   // Memory zones
   // Refused commands never reach here, so a refusal leaves memory whole
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         for (int i = 0; i < `CXW_CFG_WORDS; i++) cfg_mem[i] <= 32'h0000_0000;
         for (int i = 0; i < `CXW_OTP_WORDS; i++) otp_mem[i] <= 32'h0000_0000;
         for (int i = 0; i < `CXW_DAT_WORDS; i++) dat_mem[i] <= 32'h0000_0000;
      end else begin
         if (spare_fire && sp_sel85) begin
            cfg_mem[`CXW_CFG_SPARE_WORD][15:8] <= cmd.second_argument[7:0];
         end
         if (spare_fire && !sp_sel85) begin
            cfg_mem[`CXW_CFG_SPARE_WORD][7:0] <= cmd.second_argument[7:0];
         end
         if (in_write && is_cfg) begin
            cfg_mem[tgt[4:0]] <= in_plain;
         end
         if (in_write && is_otp) begin
            otp_mem[tgt[3:0]] <= otp_new;
         end
         if (in_write && is_dat) begin
            dat_mem[tgt] <= in_plain;
         end
      end
   end

endmodule

// [testbench/cxw_core_chk.sv]
/*
 Port checker for the spare byte update and memory write block.
 Assumes it is bound to cxw_core and sees only its ports.
*/
`timescale 1ns/100ps
module cxw_core_chk
   import cxw_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire cxw_scratch_t scratch_key_register,
   input wire logic [255:0] mac_calc,
   input wire logic cmd_busy
);
   // ==========================================
   // Properties
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire start = avs_write && (avs_address == 8'h08) && avs_writedata[0] && !cmd_busy;
   wire st_ans = avs_read && !avs_waitrequest && (avs_address == 8'h0C);
   chk_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
      else $error("write stalled");
   chk_read_first_wait: assert property ($rose(avs_read) |-> avs_waitrequest)
      else $error("read answered in first cycle");
   chk_read_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
      else $error("read not answered in one cycle");
   chk_idle_no_wait: assert property (!avs_read |-> !avs_waitrequest)
      else $error("wait without read");
   chk_busy_start: assert property (start |=> cmd_busy)
      else $error("start did not raise busy");
   chk_busy_cause: assert property (!cmd_busy && !start |=> !cmd_busy)
      else $error("busy without start");
   chk_busy_bound: assert property ($rose(cmd_busy) |-> ##[1:9] !cmd_busy)
      else $error("command ran too long");
   chk_status_busy: assert property (st_ans |-> avs_readdata[0] == $past(cmd_busy))
      else $error("status busy bit wrong");
   chk_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data moved without read");
   cover property (start);
   cover property ($rose(cmd_busy) ##8 cmd_busy);
   cover property (st_ans && avs_readdata[1]);
endmodule

// [testbench/cxw_key_host.sv]
/*
 Far side model: scratch key source and MAC hash provider.
 Assumes the bench picks the key source slot; flags always set.
*/
`timescale 1ns/100ps
module cxw_key_host
   import cxw_pkg::*;
(
   input wire logic [3:0] src,
   output cxw_scratch_t scratch_key_register,
   output logic [255:0] mac_calc
);
   // ==========================================
   // Key and hash
   always_comb begin
      scratch_key_register.valid = 1'b1;
      scratch_key_register.digest = 1'b1;
      scratch_key_register.from_rng = 1'b1;
      scratch_key_register.source_slot = src;
      for (int i = 0; i < 8; i++) begin
         scratch_key_register.key[32*i+:32] = 32'hC0DE_0000 | 32'(i);
         mac_calc[32*i+:32] = 32'hBEEF_0000 | 32'(i);
      end
   end
endmodule

// [testbench/config_extra_and_memory_write_tb.sv]
/*
 Self-checking bench for the spare byte update and memory write block.
 Assumes cxw_core, cxw_key_host and the checker are compiled first.
*/
`timescale 1ns/100ps
module config_extra_and_memory_write_tb;
   import cxw_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic cmd_busy;
   logic [3:0] src = 4'h3;
   cxw_scratch_t sk;
   logic [255:0] mac;
   int miscompares = 0;
   int check_count = 0;
   always #2 clk = ~clk;
   cxw_core i_dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .scratch_key_register(sk),
      .mac_calc(mac), .cmd_busy(cmd_busy));
   cxw_key_host i_host (.src(src), .scratch_key_register(sk), .mac_calc(mac));
   // ==========================================
   // Helpers
   function automatic logic [31:0] dw(logic [31:0] s, int i);
      return s + 32'h0101_0101 * 32'(i);
   endfunction
   task ck(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Request held until the edge that sees waitrequest low; data taken there
   task bus(input logic rw, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !rw;
      avs_write <= rw;
      do begin
         @(posedge clk);
      end while (avs_waitrequest);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task cx(input logic [7:0] op, input logic [7:0] p1, input logic [15:0] p2,
           input logic [7:0] e);
      logic [31:0] q;
      int n;
      bus(1'b1, 8'h00, {16'h0000, p1, op}, q);
      bus(1'b1, 8'h04, {16'h0000, p2}, q);
      bus(1'b1, 8'h08, 32'h1, q);
      n = 0;
      do begin
         bus(1'b0, 8'h0C, 32'h0, q);
         n++;
      end while (q[1:0] !== 2'b10 && n < 30);
      ck({30'h0, q[1:0]}, 32'h0000_0002);
      ck({24'h0, q[15:8]}, {24'h0, e});
   endtask
   task mx(input logic [1:0] z, input logic [6:0] i, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b1, 8'h14, {22'h0, z, 1'b0, i}, q);
      bus(1'b0, 8'h18, 32'h0, q);
      ck(q, e);
   endtask
   task ld(input logic [31:0] s, input logic enc);
      logic [31:0] q;
      for (int i = 0; i < 8; i++)
         bus(1'b1, 8'h20 + 8'(4*i), dw(s, i) ^ (enc ? (32'hC0DE_0000 | 32'(i)) : 32'h0), q);
   endtask
   task wd(input logic [31:0] v);
      logic [31:0] q;
      bus(1'b1, 8'h20, v, q);
   endtask
   // ==========================================
   // Scenarios
   task t_cfg;
      wd(32'h0000_0012);
      cx(8'h12, 8'h00, 16'h0008, 8'h00);
      mx(2'h0, 7'h08, 32'h0000_0012);
      wd(32'h0155_0000);
      cx(8'h12, 8'h00, 16'h0004, 8'h00);
      wd(32'h4300_0000);
      cx(8'h12, 8'h00, 16'h0005, 8'h00);
      wd(32'hFFFF_FFFF);
      cx(8'h12, 8'h00, 16'h0002, 8'h03);
      mx(2'h0, 7'h02, 32'h0);
      cx(8'h12, 8'h40, 16'h0008, 8'h0F);
      cx(8'h12, 8'h04, 16'h0008, 8'h03);
      cx(8'h12, 8'h03, 16'h0008, 8'h03);
      cx(8'h12, 8'h00, 16'h0080, 8'h03);
      cx(8'h12, 8'h82, 16'h0000, 8'h0F);
      cx(8'h20, 8'h00, 16'h0000, 8'h0F);
   endtask
   task t_spare;
      logic [31:0] q;
      bus(1'b1, 8'h10, 32'h1, q);
      cx(8'h12, 8'h00, 16'h0008, 8'h0F);
      cx(8'h20, 8'h00, 16'h00AB, 8'h00);
      cx(8'h20, 8'h00, 16'h00CD, 8'h0F);
      cx(8'h20, 8'h01, 16'h0111, 8'h03);
      cx(8'h20, 8'h02, 16'h0011, 8'h03);
      cx(8'h20, 8'h01, 16'h0011, 8'h00);
      cx(8'h20, 8'h01, 16'h0022, 8'h0F);
      mx(2'h0, 7'h15, 32'h0000_11AB);
   endtask
   task t_open;
      ld(32'hF0F0_3C3C, 1'b0);
      cx(8'h12, 8'h81, 16'h0000, 8'h00);
      mx(2'h1, 7'h01, dw(32'hF0F0_3C3C, 1));
      cx(8'h12, 8'h01, 16'h0000, 8'h0F);
      ld(32'h1122_3344, 1'b1);
      cx(8'h12, 8'hC2, 16'h0008, 8'h00);
      mx(2'h2, 7'h08, dw(32'h1122_3344, 0));
   endtask
   task t_locked;
      logic [31:0] q;
      bus(1'b1, 8'h10, 32'h3, q);
      wd(32'h0F0F_FFFF);
      cx(8'h12, 8'h01, 16'h0001, 8'h00);
      mx(2'h1, 7'h01, dw(32'hF0F0_3C3C, 1) & 32'h0F0F_FFFF);
      cx(8'h12, 8'h41, 16'h0001, 8'h0F);
      wd(32'h1234_5678);
      cx(8'h12, 8'h02, 16'h0002, 8'h00);
      cx(8'h12, 8'h42, 16'h0003, 8'h00);
      mx(2'h2, 7'h03, 32'h1234_5678);
      cx(8'h12, 8'h02, 16'h0008, 8'h0F);
      ld(32'h5566_7788, 1'b1);
      cx(8'h12, 8'h82, 16'h0008, 8'h01);
      for (int i = 0; i < 8; i++)
         bus(1'b1, 8'h40 + 8'(4*i), 32'hBEEF_0000 | 32'(i), q);
      src <= 4'h2;
      cx(8'h12, 8'h82, 16'h0008, 8'h0F);
      src <= 4'h3;
      cx(8'h12, 8'h82, 16'h0008, 8'h00);
      mx(2'h2, 7'h09, dw(32'h5566_7788, 1));
   endtask
   task finish_test;
      $display("checks=%0d mismatches=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ==========================================
   // Sequence and watchdog
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      t_cfg;
      t_spare;
      t_open;
      t_locked;
      finish_test;
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      finish_test;
   end
endmodule
bind cxw_core cxw_core_chk i_chk (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .scratch_key_register(scratch_key_register),
   .mac_calc(mac_calc), .cmd_busy(cmd_busy));
